// *** src/glm_pkg.sv ***
/*
 Constants, register map and carriers for the genset load manager.
 Assumes a 40 MHz APB clock and power values in one unsigned scale.
*/
package glm_pkg;
   // ==========================================
   // Timing
   localparam int CLK_HZ      = 40_000_000;
   localparam int TICK_S      = 1;
   localparam int TICK_CYC    = TICK_S * CLK_HZ;
   localparam int SUB_PULSE_S = 3;
   localparam int NSTEP       = 5;
   localparam int PW          = 16;
   // ==========================================
   // Register byte offsets
   localparam logic [7:0] A_CTRL    = 8'h00;
   localparam logic [7:0] A_SHED_HI = 8'h04;
   localparam logic [7:0] A_SHED_LO = 8'h08;
   localparam logic [7:0] A_ADD_DLY = 8'h0C;
   localparam logic [7:0] A_SA_DLY  = 8'h10;
   localparam logic [7:0] A_ML_ALVL = 8'h14;
   localparam logic [7:0] A_ML_SLVL = 8'h18;
   localparam logic [7:0] A_ML_AST  = 8'h1C;
   localparam logic [7:0] A_ML_AWT  = 8'h20;
   localparam logic [7:0] A_ML_SST  = 8'h24;
   localparam logic [7:0] A_ML_SWT  = 8'h28;
   localparam logic [7:0] A_STATUS  = 8'h2C;
   localparam logic [7:0] CTRL_W    = 8'h08;
   localparam logic [15:0] PWR_RST  = 16'h0000;
   localparam logic [15:0] LIM_RST  = 16'hFFFF;
   localparam logic [15:0] DLY_RST  = 16'h0001;
   // ==========================================
   // Input role config: assignment, contact sense, active level
   typedef struct packed {
      logic fs_neg;
      logic fs_nc;
      logic das_neg;
      logic das_nc;
      logic rs_neg;
      logic rs_nc;
      logic das_asg;
      logic rs_asg;
   } glm_ctrl_s;
   typedef struct packed {
      logic [PW-1:0] hi;
      logic [PW-1:0] lo;
      logic [15:0]   add_dly;
      logic [15:0]   sa_dly;
      logic [PW-1:0] ml_alvl;
      logic [PW-1:0] ml_slvl;
      logic [15:0]   ml_ast;
      logic [15:0]   ml_awt;
      logic [15:0]   ml_sst;
      logic [15:0]   ml_swt;
   } glm_lim_s;
endpackage : glm_pkg

// *** src/glm_top.sv ***
/*
 Genset load manager: shedding/dummy output, step add/subtract pulses,
 five-step load sequencer and mains override by remote-start and
 disable-auto-start inputs, with an APB register file.
 Assumes gen_power comes from logic on pclk; contact pins are async.
*/
// Our own choices: the APB register port and the placing of the registers.
// Operation
// - Shed on when power above high limit
// - Shed off below low limit; hold between
// - Dummy load output is inverse of shed
// - Step-add while power below low limit
// - Step-subtract while power above high limit
// - Add delay spaces adds and subtracts
// - Subtract-to-add delay withholds next add
// - Five loads, add upward, remove downward
// - Add step after add start delay
// - Add wait delay between step connections
// - Remove step after subtract start delay
// - Subtract wait delay between disconnections
// - Removed step gets three second pulse
// - Remote start replaces mains sensing
// - Mains indicator follows remote start
// - Contact sense and active level configurable
// - Disable-auto-start forces mains present
// - Running genset stops via normal sequences
// - Indicator shows mains present meanwhile
// - Inactive input resumes real sensing
// - Remote start overrides other inputs
`timescale 1ns/1ps
module glm_top
   import glm_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic [PW-1:0] gen_power,
   input  wire logic          genset_running,
   input  wire logic          mains_sense_ok,
   input  wire logic          rs_pin,
   input  wire logic          das_pin,
   input  wire logic          fs_pin,
   output logic               shed_out,
   output logic               dummy_out,
   output logic               step_add,
   output logic               step_sub,
   output logic [NSTEP-1:0]   load_add,
   output logic [NSTEP-1:0]   load_sub,
   output logic               mains_led,
   output logic               mains_ok_eff,
   output logic               start_req,
   output logic               cooldown_stop
);
   localparam int          PULSE_CYC = SUB_PULSE_S * TICK_CYCLES;
   localparam logic [2:0]  NSTEP_3   = 3'(NSTEP);

   function automatic logic pin_active(input logic p, input logic nc, input logic neg);
      pin_active = p ^ neg ^ nc;
   endfunction : pin_active

   function automatic logic [15:0] dec16(input logic [15:0] v, input logic t);
      dec16 = (t && v != 16'h0000) ? v - 16'h0001 : v;
   endfunction : dec16

   function automatic logic [NSTEP-1:0] therm(input logic [2:0] n);
      therm = NSTEP'((6'h01 << n) - 6'h01);
   endfunction : therm

   // ==========================================
   // Synchronisers and second tick
   logic [3:0] s1_r, s2_r;
   logic [31:0] tick_cnt_r, tick_cnt_nxt;
   logic       tick_r, tick_nxt;

   always_comb begin
      tick_nxt     = 1'b0;
      tick_cnt_nxt = tick_cnt_r + 32'h1;
      if (tick_cnt_r >= 32'(TICK_CYCLES - 1)) begin
         tick_cnt_nxt = 32'h0;
         tick_nxt     = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r       <= 4'h0;
         s2_r       <= 4'h0;
         tick_cnt_r <= 32'h0;
         tick_r     <= 1'b0;
      end else begin
         s1_r       <= {fs_pin, das_pin, rs_pin, mains_sense_ok};
         s2_r       <= s1_r;
         tick_cnt_r <= tick_cnt_nxt;
         tick_r     <= tick_nxt;
      end
   end

   // ==========================================
   // APB register file
   glm_ctrl_s ctrl_r, ctrl_nxt;
   glm_lim_s  lim_r, lim_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic        pready_r, pready_nxt;
   logic        pslverr_r, pslverr_nxt;
   logic [31:0] status;
   logic [31:0] rd;
   logic        hit;
   logic [2:0]  steps_r, steps_nxt;
   logic        shed_r, shed_nxt;
   logic        sadd_r, sadd_nxt;
   logic        ssub_r, ssub_nxt;
   logic        mok_r, mok_nxt;
   logic        sreq_r, sreq_nxt;
   logic [NSTEP-1:0] ladd_r, ladd_nxt;
   logic [NSTEP-1:0] lsub_r, lsub_nxt;

   always_comb begin
      status = {16'h0, s2_r[3:1], sreq_r, mok_r, ladd_r, steps_r, ssub_r, sadd_r, shed_r};
      hit = 1'b1;
      rd  = 32'h0;
      case (paddr)
         A_CTRL:    rd = {24'h0, ctrl_r};
         A_SHED_HI: rd = {16'h0, lim_r.hi};
         A_SHED_LO: rd = {16'h0, lim_r.lo};
         A_ADD_DLY: rd = {16'h0, lim_r.add_dly};
         A_SA_DLY:  rd = {16'h0, lim_r.sa_dly};
         A_ML_ALVL: rd = {16'h0, lim_r.ml_alvl};
         A_ML_SLVL: rd = {16'h0, lim_r.ml_slvl};
         A_ML_AST:  rd = {16'h0, lim_r.ml_ast};
         A_ML_AWT:  rd = {16'h0, lim_r.ml_awt};
         A_ML_SST:  rd = {16'h0, lim_r.ml_sst};
         A_ML_SWT:  rd = {16'h0, lim_r.ml_swt};
         A_STATUS:  rd = status;
         default:   hit = 1'b0;
      endcase
      // Answer is prepared in setup so pready can be a flop
      pready_nxt  = psel && !penable;
      prdata_nxt  = (psel && !penable && !pwrite && hit) ? rd : 32'h0;
      pslverr_nxt = psel && !penable && !hit;
      ctrl_nxt    = ctrl_r;
      lim_nxt     = lim_r;
      if (psel && penable && pready_r && pwrite && hit) begin
         case (paddr)
            A_CTRL:    ctrl_nxt        = pwdata[7:0];
            A_SHED_HI: lim_nxt.hi      = pwdata[15:0];
            A_SHED_LO: lim_nxt.lo      = pwdata[15:0];
            A_ADD_DLY: lim_nxt.add_dly = pwdata[15:0];
            A_SA_DLY:  lim_nxt.sa_dly  = pwdata[15:0];
            A_ML_ALVL: lim_nxt.ml_alvl = pwdata[15:0];
            A_ML_SLVL: lim_nxt.ml_slvl = pwdata[15:0];
            A_ML_AST:  lim_nxt.ml_ast  = pwdata[15:0];
            A_ML_AWT:  lim_nxt.ml_awt  = pwdata[15:0];
            A_ML_SST:  lim_nxt.ml_sst  = pwdata[15:0];
            A_ML_SWT:  lim_nxt.ml_swt  = pwdata[15:0];
            default:   ctrl_nxt        = ctrl_r;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r    <= CTRL_W;
         lim_r     <= {LIM_RST, PWR_RST, DLY_RST, DLY_RST, PWR_RST, LIM_RST,
                       DLY_RST, DLY_RST, DLY_RST, DLY_RST};
         prdata_r  <= 32'h0;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         ctrl_r    <= ctrl_nxt;
         lim_r     <= lim_nxt;
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // ==========================================
   // Mains override
   logic rs_act, das_act, fs_act;
   logic cool_r, cool_nxt;

   always_comb begin
      rs_act  = pin_active(s2_r[1], ctrl_r.rs_nc, ctrl_r.rs_neg);
      das_act = pin_active(s2_r[2], ctrl_r.das_nc, ctrl_r.das_neg);
      fs_act  = pin_active(s2_r[3], ctrl_r.fs_nc, ctrl_r.fs_neg);
      if (ctrl_r.rs_asg) begin
         mok_nxt  = !rs_act;
         sreq_nxt = rs_act;
      end else if (ctrl_r.das_asg && das_act) begin
         mok_nxt  = 1'b1;
         sreq_nxt = fs_act;
      end else begin
         mok_nxt  = s2_r[0];
         sreq_nxt = fs_act || !s2_r[0];
      end
      // Engine is not cut: the normal mains-wait and cooldown run first
      cool_nxt = genset_running && !sreq_nxt;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mok_r  <= 1'b1;
         sreq_r <= 1'b0;
         cool_r <= 1'b0;
      end else begin
         mok_r  <= mok_nxt;
         sreq_r <= sreq_nxt;
         cool_r <= cool_nxt;
      end
   end

   // ==========================================
   // Shedding and step add/subtract pulses
   logic [15:0] agap_r, agap_nxt;
   logic [15:0] sgap_r, sgap_nxt;
   logic [15:0] sa_r, sa_nxt;
   logic        low, high;

   always_comb begin
      low      = gen_power < lim_r.lo;
      high     = gen_power > lim_r.hi;
      shed_nxt = shed_r;
      if (high)
         shed_nxt = 1'b1;
      else if (low)
         shed_nxt = 1'b0;
      agap_nxt = dec16(agap_r, tick_r);
      sgap_nxt = dec16(sgap_r, tick_r);
      sa_nxt   = dec16(sa_r, tick_r);
      sadd_nxt = sadd_r;
      ssub_nxt = ssub_r;
      if (sadd_r) begin
         if (!low)
            sadd_nxt = 1'b0;
      end else if (low && !ssub_r && agap_r == 16'h0000 && sa_r == 16'h0000) begin
         sadd_nxt = 1'b1;
         agap_nxt = lim_r.add_dly;
      end
      if (ssub_r) begin
         if (!high) begin
            ssub_nxt = 1'b0;
            sa_nxt   = lim_r.sa_dly;
         end
      end else if (high && sgap_r == 16'h0000) begin
         ssub_nxt = 1'b1;
         sgap_nxt = lim_r.add_dly;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shed_r <= 1'b0;
         sadd_r <= 1'b0;
         ssub_r <= 1'b0;
         agap_r <= 16'h0000;
         sgap_r <= 16'h0000;
         sa_r   <= 16'h0000;
      end else begin
         shed_r <= shed_nxt;
         sadd_r <= sadd_nxt;
         ssub_r <= ssub_nxt;
         agap_r <= agap_nxt;
         sgap_r <= sgap_nxt;
         sa_r   <= sa_nxt;
      end
   end

   // ==========================================
   // Five-step sequencer
   // Start timers count whole ticks, so a start delay may run up to
   // one tick short; the per-step pulse counts cycles and is exact.
   logic [15:0] acnt_r, acnt_nxt;
   logic [15:0] scnt_r, scnt_nxt;
   logic [15:0] awt_r, awt_nxt;
   logic [15:0] swt_r, swt_nxt;
   logic [31:0] ptmr_r [NSTEP];
   logic [31:0] ptmr_nxt [NSTEP];
   logic        ml_low, ml_high;

   always_comb begin
      ml_low    = gen_power < lim_r.ml_alvl;
      ml_high   = gen_power > lim_r.ml_slvl;
      steps_nxt = steps_r;
      awt_nxt   = dec16(awt_r, tick_r);
      swt_nxt   = dec16(swt_r, tick_r);
      acnt_nxt  = 16'h0000;
      scnt_nxt  = 16'h0000;
      if (ml_low && tick_r && acnt_r != 16'hFFFF)
         acnt_nxt = acnt_r + 16'h0001;
      else if (ml_low)
         acnt_nxt = acnt_r;
      if (ml_high && tick_r && scnt_r != 16'hFFFF)
         scnt_nxt = scnt_r + 16'h0001;
      else if (ml_high)
         scnt_nxt = scnt_r;
      for (int i = 0; i < NSTEP; i++)
         ptmr_nxt[i] = (ptmr_r[i] != 32'h0) ? ptmr_r[i] - 32'h1 : 32'h0;
      if (ml_low && acnt_r >= lim_r.ml_ast && awt_r == 16'h0000 && steps_r < NSTEP_3) begin
         steps_nxt = steps_r + 3'h1;
         awt_nxt   = lim_r.ml_awt;
         acnt_nxt  = 16'h0000;
      end else if (ml_high && scnt_r >= lim_r.ml_sst && swt_r == 16'h0000 && steps_r != 3'h0) begin
         steps_nxt = steps_r - 3'h1;
         swt_nxt   = lim_r.ml_swt;
         scnt_nxt  = 16'h0000;
         ptmr_nxt[steps_nxt] = 32'(PULSE_CYC);
      end
      ladd_nxt = therm(steps_nxt);
      for (int i = 0; i < NSTEP; i++)
         lsub_nxt[i] = ptmr_nxt[i] != 32'h0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         steps_r <= 3'h0;
         acnt_r  <= 16'h0000;
         scnt_r  <= 16'h0000;
         awt_r   <= 16'h0000;
         swt_r   <= 16'h0000;
         ladd_r  <= '0;
         lsub_r  <= '0;
         for (int i = 0; i < NSTEP; i++)
            ptmr_r[i] <= 32'h0;
      end else begin
         steps_r <= steps_nxt;
         acnt_r  <= acnt_nxt;
         scnt_r  <= scnt_nxt;
         awt_r   <= awt_nxt;
         swt_r   <= swt_nxt;
         ladd_r  <= ladd_nxt;
         lsub_r  <= lsub_nxt;
         for (int i = 0; i < NSTEP; i++)
            ptmr_r[i] <= ptmr_nxt[i];
      end
   end

   // ==========================================
   // Outputs
   logic dummy_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         dummy_r <= 1'b1;
      else
         dummy_r <= !shed_nxt;
   end

   assign prdata        = prdata_r;
   assign pready        = pready_r;
   assign pslverr       = pslverr_r;
   assign shed_out      = shed_r;
   assign dummy_out     = dummy_r;
   assign step_add      = sadd_r;
   assign step_sub      = ssub_r;
   assign load_add      = ladd_r;
   assign load_sub      = lsub_r;
   assign mains_led     = mok_r;
   assign mains_ok_eff  = mok_r;
   assign start_req     = sreq_r;
   assign cooldown_stop = cool_r;
endmodule : glm_top

// *** verif/glm_top_props.sv ***
/*
 Port checker for glm_top: shedding, step outputs, sequencer pulses, mains outputs, APB answer.
 Assumes it is bound into glm_top and shares its TICK_CYCLES.
*/
`timescale 1ns/1ps
module glm_top_props
   import glm_pkg::*;
#(
   parameter int TICK_CYCLES = 20
) (
   input wire logic             pclk,
   input wire logic             presetn,
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pready,
   input wire logic             pslverr,
   input wire logic             genset_running,
   input wire logic             shed_out,
   input wire logic             dummy_out,
   input wire logic             step_add,
   input wire logic             step_sub,
   input wire logic [NSTEP-1:0] load_add,
   input wire logic [NSTEP-1:0] load_sub,
   input wire logic             mains_led,
   input wire logic             mains_ok_eff,
   input wire logic             start_req,
   input wire logic             cooldown_stop
);
   localparam int PULSE = SUB_PULSE_S * TICK_CYCLES;
   int cnt_r   [NSTEP];
   int cnt_nxt [NSTEP];
   // ==========================================
   // Pulse length counters, one per step since pulses may overlap
   always_comb begin
      for (int k = 0; k < NSTEP; k++) begin
         cnt_nxt[k] = load_sub[k] ? cnt_r[k] + 1 : 0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = 0; k < NSTEP; k++) begin
            cnt_r[k] <= 0;
         end
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
   // ==========================================
   // Properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   dummy_inv_a: assert property (dummy_out == !shed_out)
      else $error("dummy output not inverse of shed");
   ready_setup_a: assert property (psel && !penable |=> pready)
      else $error("no ready in access phase");
   ready_drop_a: assert property (pready |=> !pready)
      else $error("ready held past access");
   err_only_a: assert property (pslverr |-> pready)
      else $error("error outside access");
   therm_a: assert property (((load_add + 1) & load_add) == 0)
      else $error("connected steps not contiguous");
   step_one_a: assert property ($changed(load_add) |->
      load_add == {$past(load_add[NSTEP-2:0]), 1'b1} || load_add == $past(load_add) >> 1)
      else $error("step change not one at the end");
   no_both_a: assert property (!(step_add && step_sub))
      else $error("add and subtract together");
   ind_same_a: assert property (mains_led == mains_ok_eff)
      else $error("indicator differs from mains state");
   cool_a: assert property ($past(presetn) |-> cooldown_stop == ($past(genset_running) && !start_req))
      else $error("stop flag wrong");
   for (genvar k = 0; k < NSTEP; k++) begin : g_step
      sub_tied_a: assert property ($fell(load_add[k]) |-> $rose(load_sub[k]))
         else $error("removal without subtract pulse");
      sub_len_a: assert property ($fell(load_sub[k]) |-> cnt_r[k] == PULSE)
         else $error("subtract pulse length wrong");
      sub_max_a: assert property (cnt_r[k] <= PULSE)
         else $error("subtract pulse too long");
   end
   cover property (load_add == 5'h1F);
   cover property ($rose(load_sub[0]));
   cover property ($rose(step_add));
   cover property (pslverr);
endmodule : glm_top_props

bind glm_top glm_top_props #(.TICK_CYCLES(TICK_CYCLES)) glm_top_props_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .genset_running(genset_running), .shed_out(shed_out), .dummy_out(dummy_out),
   .step_add(step_add), .step_sub(step_sub), .load_add(load_add), .load_sub(load_sub),
   .mains_led(mains_led), .mains_ok_eff(mains_ok_eff), .start_req(start_req),
   .cooldown_stop(cooldown_stop)
);

// *** verif/glm_field.sv ***
/*
 Contact inputs of the field side: turns wanted role states into pin levels.
 Assumes the bench mirrors the contact wiring choice in ctrl.
*/
`timescale 1ns/1ps
module glm_field
   import glm_pkg::*;
(
   input  wire glm_ctrl_s ctrl,
   input  wire logic      rs_act,
   input  wire logic      das_act,
   input  wire logic      fs_act,
   output logic           rs_pin,
   output logic           das_pin,
   output logic           fs_pin
);
   // Software owns this setting; kept so these roles raise no alarm
   localparam int input_alarm_behaviour_setting = 3;
   // Contact sense and rail choice each flip the pin seen for an active role
   assign rs_pin  = rs_act ^ ctrl.rs_nc ^ ctrl.rs_neg;
   assign das_pin = das_act ^ ctrl.das_nc ^ ctrl.das_neg;
   assign fs_pin  = fs_act ^ ctrl.fs_nc ^ ctrl.fs_neg;
endmodule : glm_field

// *** verif/tb_genset_load_management.sv ***
/*
 Self-checking bench for glm_top with a queue model of the steps and a mains model.
 Assumes TICK_CYCLES shortened to 20 so one tick is 20 clocks.
*/
`timescale 1ns/1ps
module tb_genset_load_management
   import glm_pkg::*;
;
   localparam int T = 20;
   localparam logic [7:0]  RA [10] = '{A_SHED_HI, A_SHED_LO, A_ADD_DLY, A_SA_DLY, A_ML_ALVL,
                                       A_ML_SLVL, A_ML_AST, A_ML_AWT, A_ML_SST, A_ML_SWT};
   localparam logic [15:0] RV [10] = '{LIM_RST, PWR_RST, DLY_RST, DLY_RST, PWR_RST,
                                       LIM_RST, DLY_RST, DLY_RST, DLY_RST, DLY_RST};
   localparam logic [15:0] WV [10] = '{16'h03E8, 16'h01F4, 16'h0003, 16'h0004, 16'h012C,
                                       16'h07D0, 16'h0003, 16'h0003, 16'h0002, 16'h0004};
   logic             pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]       paddr = 8'h00;
   logic [31:0]      pwdata = 32'h0, prdata;
   logic [PW-1:0]    gen_power = 16'h02BC;
   logic             genset_running = 1'b0, mains_sense_ok = 1'b1, rs_act = 1'b0, das_act = 1'b0;
   logic             fs_act = 1'b0, pready, pslverr, rs_pin, das_pin, fs_pin, shed_out, dummy_out;
   logic             step_add, step_sub, mains_led, mains_ok_eff, start_req, cooldown_stop;
   logic [NSTEP-1:0] load_add, load_sub;
   glm_ctrl_s        ctrl = 8'h08;
   int               error_cnt = 0, samples_checked = 0;
   int               steps_q [$];
   always #12.5 pclk = ~pclk;
   glm_top #(.TICK_CYCLES(T)) glm_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .gen_power(gen_power), .genset_running(genset_running),
      .mains_sense_ok(mains_sense_ok), .rs_pin(rs_pin), .das_pin(das_pin), .fs_pin(fs_pin),
      .shed_out(shed_out), .dummy_out(dummy_out), .step_add(step_add), .step_sub(step_sub),
      .load_add(load_add), .load_sub(load_sub), .mains_led(mains_led), .mains_ok_eff(mains_ok_eff),
      .start_req(start_req), .cooldown_stop(cooldown_stop));
   glm_field glm_field_inst (.ctrl(ctrl), .rs_act(rs_act), .das_act(das_act), .fs_act(fs_act),
      .rs_pin(rs_pin), .das_pin(das_pin), .fs_pin(fs_pin));
   // ==========================================
   // Shared tasks
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic pw(input logic [PW-1:0] p);
      @(posedge pclk);
      gen_power <= p;
      repeat (4) @(negedge pclk);
   endtask : pw
   // Counts clocks until a masked output moves; the limit keeps a stuck block from hanging
   task automatic wait_chg(input logic [6:0] m, input int maxc, output int n);
      logic [6:0] s0;
      s0 = {step_sub, step_add, load_add} & m;
      n = 0;
      while (({step_sub, step_add, load_add} & m) === s0 && n < maxc) begin
         @(negedge pclk);
         n++;
      end
   endtask : wait_chg
   task automatic rng(input int n, input int dmin, input int dmax);
      chk({31'h0, n >= (dmin - 1) * T - 10 && n <= (dmax + 1) * T + 4}, 32'h1);
   endtask : rng
   function automatic logic [1:0] mains_m(glm_ctrl_s c, logic rs, logic das, logic fs, logic s);
      if (c.rs_asg) return {!rs, rs};
      if (c.das_asg && das) return {1'b1, fs};
      return {s, fs | !s};
   endfunction : mains_m
   initial begin
      repeat (30000) @(posedge pclk);
      error_cnt++;
      results();
   end
   // ==========================================
   // Main sequence
   initial begin
      logic [31:0] q;
      logic        e;
      int          n;
      logic [1:0]  me;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      q = $urandom(32'h9A92244F);
      apb(1'b0, A_CTRL, 32'h0, q, e);
      chk(q, {24'h0, CTRL_W});
      apb(1'b0, 8'h40, 32'h0, q, e);
      chk(q, 32'h0);
      chk(e, 1'b1);
      apb(1'b1, A_STATUS, 32'hFFFF, q, e);
      chk(e, 1'b0);
      for (int i = 0; i < 10; i++) begin
         apb(1'b0, RA[i], 32'h0, q, e);
         chk(q, RV[i]);
         apb(1'b1, RA[i], WV[i], q, e);
         apb(1'b0, RA[i], 32'h0, q, e);
         chk(q, WV[i]);
      end
      pw(16'h04B0);
      chk({shed_out, dummy_out, step_sub, step_add}, 4'b1010);
      pw(16'h0320);
      chk({shed_out, step_sub}, 2'b10);
      pw(16'h0190);
      chk(shed_out, 1'b0);
      wait_chg(7'h20, 10 * T, n);
      rng(n, WV[3], WV[3]);
      chk(step_add, 1'b1);
      pw(16'h02BC);
      chk(step_add, 1'b0);
      pw(16'h0190);
      wait_chg(7'h20, 10 * T, n);
      rng(n, WV[2], WV[2]);
      pw(16'h0064);
      repeat (25) @(posedge pclk);
      pw(16'h02BC);
      pw(16'h0064);
      repeat (25) @(posedge pclk);
      pw(16'h02BC);
      repeat (4 * T) @(posedge pclk);
      chk(load_add, 5'h00);
      pw(16'h0064);
      for (int k = 1; k <= NSTEP; k++) begin
         wait_chg(7'h1F, 12 * T, n);
         rng(n, k == 1 ? WV[6] : WV[7], WV[6] + WV[7]);
         steps_q.push_back(k - 1);
         chk(load_add, (1 << steps_q.size()) - 1);
      end
      wait_chg(7'h1F, 6 * T, n);
      chk(n, 6 * T);
      pw(16'h0BB8);
      for (int k = 1; k <= NSTEP; k++) begin
         wait_chg(7'h1F, 12 * T, n);
         rng(n, k == 1 ? WV[8] : WV[9], WV[8] + WV[9]);
         chk(load_sub, 1 << steps_q.pop_back());
         chk(load_add, (1 << steps_q.size()) - 1);
      end
      pw(16'h02BC);
      repeat (4 * T) @(posedge pclk);
      chk(load_sub, 5'h00);
      for (int i = 0; i < 30; i++) begin
         ctrl <= glm_ctrl_s'(8'($urandom));
         {rs_act, das_act, fs_act, mains_sense_ok, genset_running} <= 5'($urandom);
         @(posedge pclk);
         apb(1'b1, A_CTRL, {24'h0, ctrl}, q, e);
         repeat (6) @(negedge pclk);
         me = mains_m(ctrl, rs_act, das_act, fs_act, mains_sense_ok);
         chk({mains_led, mains_ok_eff, start_req}, {me[1], me});
         chk(cooldown_stop, genset_running & !me[0]);
         apb(1'b0, A_STATUS, 32'h0, q, e);
         chk(q[12:11], {me[0], me[1]});
      end
      results();
   end
endmodule : tb_genset_load_management
